// *** rtl/bsram_consts.svh ***
// offsets, field positions and reset values of the byte-select sram interface
`ifndef BSRAM_CONSTS_SVH
`define BSRAM_CONSTS_SVH
`define BSRAM_AWIDTH        8
`define BSRAM_OFS_WAIT_CTRL 8'h00
`define BSRAM_OFS_STATUS    8'h04
`define BSRAM_BIT_SCHEME    0
`define BSRAM_POS_SETUP     2
`define BSRAM_POS_ACCESS    4
`define BSRAM_POS_HOLD      8
`define BSRAM_WAIT_CTRL_RST 32'h0000_0000
`define BSRAM_BIT_BUSY      0
`define BSRAM_BIT_STROBE    1
`endif

// *** rtl/bsram_pkg.sv ***
// types shared by the byte-select sram interface
package bsram_pkg;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_SETUP  = 5'b00010,
		ST_STROBE = 5'b00100,
		ST_HOLD   = 5'b01000,
		ST_DONE   = 5'b10000
	} state_t;
	typedef struct packed {
		logic        write;
		logic        word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} access_t;
	typedef struct packed {
		logic        cs_n;
		logic        rd_n;
		logic        rw_n;
		logic        ub_n;
		logic        lb_n;
		logic [23:0] addr;
		logic [15:0] dq_o;
		logic        dq_oe;
	} sram_pins_t;
	typedef struct packed {
		logic       scheme;
		logic [1:0] setup;
		logic [3:0] access;
		logic [1:0] hold;
	} wait_cfg_t;
endpackage : bsram_pkg

// *** rtl/byte_select_sram_interface.sv ***
// sram access engine with upper and lower byte selects on a 16-bit bus
`timescale 1ns/10ps
`default_nettype none
`include "bsram_consts.svh"

// Notes on behaviour
// - drive 16-bit data, separate upper/lower selects
// - scheme 0 writes time like ordinary space
// - scheme 0 reads also assert byte selects
// - scheme 0 data framed around select strobes
// - scheme 1 write strobe is read/write pin
// - scheme 1 data held hold-wait cycles after
// - software waits lengthen setup, strobe and hold phases
module byte_select_sram_interface (
	input  wire logic                      CORE_CLK,
	input  wire logic                      RST_N,
	input  wire logic [`BSRAM_AWIDTH-1:0]  REG_ADDR,
	input  wire logic [31:0]               REG_WDATA,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	output logic      [31:0]               REG_RDATA,
	input  wire logic                      REQ,
	input  wire bsram_pkg::access_t        REQ_CMD,
	output logic                           BUSY,
	output logic                           ACK,
	output logic      [15:0]               RDATA,
	output bsram_pkg::sram_pins_t          SRAM_OUT,
	input  wire logic [15:0]               DQ_IN
);
	import bsram_pkg::*;

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	wait_cfg_t   cfg_q;
	logic [31:0] rdata_q;
	state_t      state_q;
	state_t      state_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	access_t     op_q;
	sram_pins_t  pins_q;
	logic [15:0] rd_q;
	logic        ack_q;
	logic        busy_q;

	wire sel_ctrl = (REG_ADDR == `BSRAM_OFS_WAIT_CTRL);
	wire sel_stat = (REG_ADDR == `BSRAM_OFS_STATUS);
	wire [31:0] ctrl_view = {22'h0, cfg_q.hold, cfg_q.access, cfg_q.setup, 1'b0, cfg_q.scheme};
	wire [31:0] stat_view = {30'h0, (state_q == ST_STROBE), busy_q};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_view : (sel_stat ? stat_view : 32'h0);
	// reset image of the control word, split into its fields below
	wire [31:0] ctrl_rst = `BSRAM_WAIT_CTRL_RST;

	// configuration write and one-cycle read answer
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cfg_q.scheme <= ctrl_rst[`BSRAM_BIT_SCHEME];
			cfg_q.setup  <= ctrl_rst[`BSRAM_POS_SETUP +: 2];
			cfg_q.access <= ctrl_rst[`BSRAM_POS_ACCESS +: 4];
			cfg_q.hold   <= ctrl_rst[`BSRAM_POS_HOLD +: 2];
			rdata_q <= 32'h0;
		end else begin
			if (REG_WR && sel_ctrl) begin
				cfg_q.scheme <= REG_WDATA[`BSRAM_BIT_SCHEME];
				cfg_q.setup  <= REG_WDATA[`BSRAM_POS_SETUP +: 2];
				cfg_q.access <= REG_WDATA[`BSRAM_POS_ACCESS +: 4];
				cfg_q.hold   <= REG_WDATA[`BSRAM_POS_HOLD +: 2];
			end
			rdata_q <= REG_RD ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	wire take = (state_q == ST_IDLE) && REQ;
	wire cnt_zero = (cnt_q == 4'h0);
	wire [3:0] setup_ld = {2'h0, cfg_q.setup};
	wire [3:0] hold_ld = {2'h0, cfg_q.hold} - 4'h1;

	// phase walk, wait counts taken from the control register
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (REQ) begin
					state_d = ST_SETUP;
					cnt_d   = setup_ld;
				end
			end
			ST_SETUP: begin
				if (cnt_zero) begin
					state_d = ST_STROBE;
					cnt_d   = cfg_q.access;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			ST_STROBE: begin
				if (!cnt_zero) begin
					cnt_d = cnt_q - 4'h1;
				end else if (cfg_q.hold != 2'h0) begin
					state_d = ST_HOLD;
					cnt_d   = hold_ld;
				end else begin
					state_d = ST_DONE;
				end
			end
			ST_HOLD: begin
				if (cnt_zero) begin
					state_d = ST_DONE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = 4'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// pin decode from the next phase, so pins come from flops
	// ----------------------------------------------------------------
	access_t op_d;
	assign op_d = take ? REQ_CMD : op_q;
	wire in_acc = (state_d == ST_SETUP) || (state_d == ST_STROBE) || (state_d == ST_HOLD);
	wire strobe = (state_d == ST_STROBE);
	wire wr = op_d.write;
	wire lane_u = op_d.word || !op_d.addr[0];
	wire lane_l = op_d.word || op_d.addr[0];
	wire sel_on = cfg_q.scheme ? in_acc : strobe;
	wire rw_on = cfg_q.scheme ? (strobe && wr) : (in_acc && wr);
	wire [15:0] lane_data = op_d.word ? op_d.wdata : {op_d.wdata[7:0], op_d.wdata[7:0]};
	sram_pins_t pins_d;
	assign pins_d.cs_n  = !in_acc;
	assign pins_d.rd_n  = !(strobe && !wr);
	assign pins_d.rw_n  = !rw_on;
	assign pins_d.ub_n  = !(sel_on && lane_u);
	assign pins_d.lb_n  = !(sel_on && lane_l);
	assign pins_d.addr  = op_d.addr;
	assign pins_d.dq_o  = lane_data;
	assign pins_d.dq_oe = in_acc && wr;

	// byte reads return on the low half
	wire [15:0] rd_pick = op_q.word ? DQ_IN : {8'h0, (op_q.addr[0] ? DQ_IN[7:0] : DQ_IN[15:8])};
	wire rd_cap = (state_q == ST_STROBE) && cnt_zero && !op_q.write;

	// state, operation, pins and answer flops
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			op_q    <= '0;
			pins_q  <= '{cs_n: 1'b1, rd_n: 1'b1, rw_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1,
				addr: 24'h0, dq_o: 16'h0, dq_oe: 1'b0};
			rd_q    <= 16'h0;
			ack_q   <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			op_q    <= op_d;
			pins_q  <= pins_d;
			rd_q    <= rd_cap ? rd_pick : rd_q;
			ack_q   <= (state_d == ST_DONE);
			busy_q  <= (state_d != ST_IDLE);
		end
	end

	assign REG_RDATA = rdata_q;
	assign SRAM_OUT  = pins_q;
	assign RDATA     = rd_q;
	assign ACK       = ack_q;
	assign BUSY      = busy_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [3:0] hcnt_q;
	logic [4:0] scnt_q;

	// helper counters for hold and strobe lengths
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			hcnt_q <= 4'h0;
			scnt_q <= 5'h0;
		end else begin
			hcnt_q <= (pins_q.dq_oe && pins_q.rw_n) ? hcnt_q + 4'h1 : 4'h0;
			scnt_q <= !pins_q.rd_n ? scnt_q + 5'h1 : 5'h0;
		end
	end

	chk_drive_in_cs: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		pins_q.dq_oe |-> !pins_q.cs_n) else $error("data driven outside chip select");
	chk_normal_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(!cfg_q.scheme && pins_q.dq_oe) |-> !pins_q.rw_n) else $error("scheme 0 write strobe gap");
	chk_read_selects: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(!cfg_q.scheme && !pins_q.rd_n) |-> (!pins_q.ub_n || !pins_q.lb_n))
		else $error("read without byte select");
	chk_select_framing: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(!cfg_q.scheme && !pins_q.rw_n && $fell(pins_q.ub_n && pins_q.lb_n))
		|-> pins_q.dq_oe && $past(pins_q.dq_oe)) else $error("select not framed by data");
	chk_rw_strobe: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(cfg_q.scheme && $fell(pins_q.rw_n))
		|-> (pins_q.dq_oe && (!$past(pins_q.ub_n) || !$past(pins_q.lb_n))))
		else $error("scheme 1 strobe without select or data");
	chk_hold_length: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(cfg_q.scheme && $fell(pins_q.dq_oe)) |-> (hcnt_q == {2'h0, cfg_q.hold}))
		else $error("write data hold length wrong");
	chk_strobe_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		$rose(pins_q.rd_n) |-> (scnt_q == {1'b0, cfg_q.access} + 5'h1))
		else $error("read strobe length wrong");
	chk_lane_select: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(!pins_q.cs_n && !op_q.word) |-> (pins_q.ub_n || pins_q.lb_n))
		else $error("byte access asserted both selects");
endmodule // byte_select_sram_interface

`default_nettype wire

// *** tb/sram_partner.sv ***
// behavioural sram with upper and lower byte selects, far side of the interface
`timescale 1ns/10ps
`default_nettype none
module sram_partner
	import bsram_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        scheme,
	input  wire sram_pins_t  pins,
	output logic [15:0]      dq
);
	// ----------------------------------------
	// storage and strobes
	// ----------------------------------------
	logic [15:0] mem [0:15];
	logic [15:0] last_q = 16'h0000;
	logic [3:0]  idx;
	logic        stb;
	logic        rd_on;
	assign idx   = pins.addr[4:1];
	// capture strobe: selects in scheme 0, read/write pin in scheme 1
	assign stb   = scheme ? !pins.rw_n : (!pins.rw_n && !(pins.ub_n && pins.lb_n));
	assign rd_on = !pins.cs_n && !pins.rd_n && !pins.dq_oe;
	// released bus shows the inverse of its last value
	assign dq    = rd_on ? mem[idx] : ~last_q;
	// data must stand on the bus while the strobe is active
	always @(posedge clk) begin
		if (rd_on)
			last_q <= dq;
		if (!pins.cs_n && stb && pins.dq_oe && !pins.ub_n)
			mem[idx][15:8] <= pins.dq_o[15:8];
		if (!pins.cs_n && stb && pins.dq_oe && !pins.lb_n)
			mem[idx][7:0] <= pins.dq_o[7:0];
	end
endmodule // sram_partner
`default_nettype wire

// *** tb/byte_select_sram_interface_bench.sv ***
// self-checking bench for the byte-select sram interface
`timescale 1ns/10ps
`default_nettype none
module byte_select_sram_interface_bench;
	import bsram_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
	logic        busy, ack, scheme = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] rdata, dq;
	access_t     cmd = '0;
	sram_pins_t  pins;
	int          mismatches = 0, total_checks = 0;
	always #12.5 clk = ~clk;
	byte_select_sram_interface i_dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.REQ(req), .REQ_CMD(cmd), .BUSY(busy), .ACK(ack), .RDATA(rdata), .SRAM_OUT(pins),
		.DQ_IN(dq));
	sram_partner i_sram (.clk(clk), .scheme(scheme), .pins(pins), .dq(dq));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask
	// one access: latency, hold cycles after the write strobe, lanes selected, read data
	task acc(input logic wr, wd, input logic [23:0] a, input logic [15:0] d,
		input int lat, hold, input logic [1:0] lanes);
		int n, h;
		logic [1:0] seen;
		logic sw;
		n = 0;
		h = 0;
		seen = 2'b00;
		sw = 1'b0;
		@(posedge clk);
		req <= 1'b1;
		cmd <= '{wr, wd, a, d};
		@(posedge clk);
		req <= 1'b0;
		while (n < 40) begin
			@(negedge clk);
			n++;
			seen = seen | {~pins.ub_n, ~pins.lb_n};
			if (pins.rw_n === 1'b0)
				sw = 1'b1;
			if (sw && pins.rw_n && pins.dq_oe)
				h++;
			if (ack === 1'b1)
				break;
		end
		chk(n, lat);
		chk({31'h0, busy}, 32'h0000_0001);
		chk(h, hold);
		chk({30'h0, seen}, {30'h0, lanes});
		if (!wr)
			chk({16'h0, rdata}, {16'h0, d});
		@(negedge clk);
		chk({31'h0, busy}, 32'h0000_0000);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({24'h0, pins.cs_n, pins.rd_n, pins.rw_n, pins.ub_n, pins.lb_n, pins.dq_oe, ack, busy}, 32'h0000_00F8);
		wr_reg(8'h10, 32'hFFFF_FFFF);
		rd_reg(8'h00, 32'h0000_0000);
		rd_reg(8'h10, 32'h0000_0000);
		rd_reg(8'h04, 32'h0000_0000);
		acc(1'b1, 1'b1, 24'h000010, 16'hA5C3, 3, 0, 2'b11);
		acc(1'b0, 1'b1, 24'h000010, 16'hA5C3, 3, 0, 2'b11);
		acc(1'b1, 1'b0, 24'h000021, 16'h005A, 3, 0, 2'b01);
		acc(1'b1, 1'b0, 24'h000020, 16'h003C, 3, 0, 2'b10);
		acc(1'b0, 1'b1, 24'h000020, 16'h3C5A, 3, 0, 2'b11);
		acc(1'b0, 1'b0, 24'h000021, 16'h005A, 3, 0, 2'b01);
		wr_reg(8'h00, 32'h0000_0125);
		scheme <= 1'b1;
		rd_reg(8'h00, 32'h0000_0125);
		acc(1'b1, 1'b1, 24'h000030, 16'h9E61, 7, 1, 2'b11);
		acc(1'b0, 1'b1, 24'h000030, 16'h9E61, 7, 0, 2'b11);
		wr_reg(8'h00, 32'h0000_0301);
		acc(1'b1, 1'b0, 24'h000041, 16'h0077, 6, 3, 2'b01);
		acc(1'b0, 1'b0, 24'h000041, 16'h0077, 6, 0, 2'b01);
		// scheme 0 with setup, access and hold waits, then status while busy
		wr_reg(8'h00, 32'h0000_0114);
		scheme <= 1'b0;
		acc(1'b1, 1'b1, 24'h000050, 16'h1234, 6, 0, 2'b11);
		acc(1'b0, 1'b1, 24'h000050, 16'h1234, 6, 0, 2'b11);
		@(posedge clk);
		req <= 1'b1;
		cmd <= '{1'b0, 1'b1, 24'h000050, 16'h0000};
		@(posedge clk);
		req <= 1'b0;
		rd_reg(8'h04, 32'h0000_0001);
		rd_reg(8'h04, 32'h0000_0003);
		repeat (4) @(posedge clk);
		rd_reg(8'h04, 32'h0000_0000);
		end_of_test;
	end
	// watchdog well beyond the hundred-odd cycles the sequence needs
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		end_of_test;
	end
endmodule // byte_select_sram_interface_bench
`default_nettype wire
